// ---- design/obt_output_regs.sv ----
`timescale 1ns/10ps
`default_nettype none

module obt_output_regs
  import obt_pkg::*;
#(
  parameter int ADDR_W = OBT_ADDR_W,
  parameter int WORD_W = OBT_WORD_W
)
(
  input  wire logic              SYS_CLK,
  input  wire logic              RESETN,
  input  wire logic [15:0]       ORIENTATION_FILTER_CONFIG,
  input  wire logic              SENSOR_STROBE,
  input  wire logic [WORD_W-1:0] PITCH_ANGLE,
  input  wire logic [WORD_W-1:0] YAW_ANGLE,
  input  wire logic [WORD_W-1:0] MATRIX_C31,
  input  wire logic [WORD_W-1:0] MATRIX_C32,
  input  wire logic [WORD_W-1:0] MATRIX_C33,
  input  wire logic [WORD_W-1:0] TEMPERATURE,
  input  wire logic              PRESSURE_STROBE,
  input  wire logic [2*WORD_W-1:0] PRESSURE,
  input  wire logic              REG_RD,
  input  wire logic              REG_WR,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  output var  logic [WORD_W-1:0] REG_RDATA,
  output var  logic              REG_RVALID,
  output var  logic              REG_WR_REJECT
);

  //========================================================================
  // Orientation source selection
  //========================================================================
  logic              fmt_sel;
  logic [WORD_W-1:0] pitch_clamped;
  logic [WORD_W-1:0] pitch_word;
  logic [WORD_W-1:0] yaw_word;

  assign fmt_sel = ORIENTATION_FILTER_CONFIG[OBT_FMT_BIT];

  // Filter may overshoot near the pole, so pitch is held to +/-90 degrees
  always_comb
  begin
    pitch_clamped = PITCH_ANGLE;
    if ($signed(PITCH_ANGLE) > $signed(OBT_PITCH_MAX))
    begin
      pitch_clamped = OBT_PITCH_MAX;
    end
    else if ($signed(PITCH_ANGLE) < $signed(OBT_PITCH_MIN))
    begin
      pitch_clamped = OBT_PITCH_MIN;
    end
  end

  always_comb
  begin
    if (fmt_sel == OBT_FMT_MATRIX)
    begin
      pitch_word = MATRIX_C31;
      yaw_word   = MATRIX_C32;
    end
    else
    begin
      pitch_word = pitch_clamped;
      yaw_word   = YAW_ANGLE;
    end
  end

  //========================================================================
  // Held output words
  //========================================================================
  logic [WORD_W-1:0] pitch_q;
  logic [WORD_W-1:0] yaw_q;
  logic [WORD_W-1:0] c33_q;
  logic [WORD_W-1:0] temp_q;
  logic [WORD_W-1:0] coarse_q;
  logic [WORD_W-1:0] fine_q;

  // Format is taken at the strobe so one sample never mixes formats
  obt_word_reg #(.WIDTH(WORD_W)) u_pitch
  (
    .clk  (SYS_CLK),
    .rstn (RESETN),
    .load (SENSOR_STROBE),
    .d    (pitch_word),
    .q    (pitch_q)
  );

  obt_word_reg #(.WIDTH(WORD_W)) u_yaw
  (
    .clk  (SYS_CLK),
    .rstn (RESETN),
    .load (SENSOR_STROBE),
    .d    (yaw_word),
    .q    (yaw_q)
  );

  obt_word_reg #(.WIDTH(WORD_W)) u_c33
  (
    .clk  (SYS_CLK),
    .rstn (RESETN),
    .load (SENSOR_STROBE),
    .d    (MATRIX_C33),
    .q    (c33_q)
  );

  obt_word_reg #(.WIDTH(WORD_W)) u_temp
  (
    .clk  (SYS_CLK),
    .rstn (RESETN),
    .load (SENSOR_STROBE),
    .d    (TEMPERATURE),
    .q    (temp_q)
  );

  obt_word_reg #(.WIDTH(WORD_W)) u_coarse
  (
    .clk  (SYS_CLK),
    .rstn (RESETN),
    .load (PRESSURE_STROBE),
    .d    (PRESSURE[2*WORD_W-1:WORD_W]),
    .q    (coarse_q)
  );

  obt_word_reg #(.WIDTH(WORD_W)) u_fine
  (
    .clk  (SYS_CLK),
    .rstn (RESETN),
    .load (PRESSURE_STROBE),
    .d    (PRESSURE[WORD_W-1:0]),
    .q    (fine_q)
  );

  //========================================================================
  // Address decode
  //========================================================================
  obt_sel_t sel;

  always_comb
  begin
    unique case (REG_ADDR)
      OBT_OFS_TEMP:         sel = OBT_SEL_TEMP;
      OBT_OFS_PRESS_FINE:   sel = OBT_SEL_PRESS_FINE;
      OBT_OFS_PRESS_COARSE: sel = OBT_SEL_PRESS_COARSE;
      OBT_OFS_PITCH_C31:    sel = OBT_SEL_PITCH_C31;
      OBT_OFS_YAW_C32:      sel = OBT_SEL_YAW_C32;
      OBT_OFS_C33:          sel = OBT_SEL_C33;
      default:              sel = OBT_SEL_NONE;
    endcase
  end

  //========================================================================
  // Pressure pair coherence
  //========================================================================
  // A coarse read freezes the fine word, so a later fine read pairs with it
  // even if a new pressure sample lands in between. After a coarse read alone,
  // the next fine read, however late, still returns the word frozen at that read.
  logic              fine_hold;
  logic [WORD_W-1:0] fine_shadow;
  logic              next_fine_hold;
  logic [WORD_W-1:0] next_fine_shadow;
  logic [WORD_W-1:0] fine_view;

  assign fine_view = fine_hold ? fine_shadow : fine_q;

  always_comb
  begin
    next_fine_hold   = fine_hold;
    next_fine_shadow = fine_shadow;
    if (REG_RD && sel == OBT_SEL_PRESS_COARSE)
    begin
      next_fine_hold   = 1'b1;
      next_fine_shadow = fine_q;
    end
    else if (REG_RD && sel == OBT_SEL_PRESS_FINE)
    begin
      next_fine_hold = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      fine_hold   <= 1'b0;
      fine_shadow <= OBT_RESET_WORD;
    end
    else
    begin
      fine_hold   <= next_fine_hold;
      fine_shadow <= next_fine_shadow;
    end
  end

  //========================================================================
  // Read and write port
  //========================================================================
  logic [WORD_W-1:0] next_rdata;
  logic              next_rvalid;
  logic              next_wr_reject;

  always_comb
  begin
    next_rdata     = REG_RDATA;
    next_rvalid    = REG_RD;
    // Writes have no target here; they are only reported
    next_wr_reject = REG_WR;
    if (REG_RD)
    begin
      unique case (sel)
        OBT_SEL_TEMP:         next_rdata = temp_q;
        OBT_SEL_PRESS_FINE:   next_rdata = fine_view;
        OBT_SEL_PRESS_COARSE: next_rdata = coarse_q;
        OBT_SEL_PITCH_C31:    next_rdata = pitch_q;
        OBT_SEL_YAW_C32:      next_rdata = yaw_q;
        OBT_SEL_C33:          next_rdata = c33_q;
        OBT_SEL_NONE:         next_rdata = OBT_UNMAPPED_WORD;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      REG_RDATA     <= OBT_RESET_WORD;
      REG_RVALID    <= 1'b0;
      REG_WR_REJECT <= 1'b0;
    end
    else
    begin
      REG_RDATA     <= next_rdata;
      REG_RVALID    <= next_rvalid;
      REG_WR_REJECT <= next_wr_reject;
    end
  end

endmodule

`default_nettype wire

// ---- design/obt_pkg.sv ----
//==========================================================================
// Orientation, pressure and temperature output registers
//==========================================================================
// Behaviour
// - In Euler format the pitch register holds the pitch angle at 180/2^15 degrees per count, clamped to 0xC000..0x3FFF.
// - In matrix format the pitch register holds element C31 as a 16-bit signed fraction of 1/2^15 per count.
// - In Euler format the yaw register holds the yaw angle at 180/2^15 degrees per count over the full signed range.
// - In matrix format the yaw register holds element C32 as a 16-bit signed fraction of 1/2^15 per count.
// - Element C33 always has its own 16-bit signed register at 1/2^15 per count, with -1 as 0x8000.
// - The coarse and fine pressure words together form one 32-bit signed value, coarse word on top.
// - The coarse pressure word alone is a 16-bit signed pressure of 40 microbar per count, zero pressure as 0x0000.
// - The fine pressure word carries extra resolution, its top bit worth 20 microbar and each lower bit half the one above.
// - The temperature register holds a 16-bit signed value at 0.00565 C per count, zero meaning 25 C.
// - Orientation registers carry Euler values when the format select bit is 0 and matrix elements when it is 1.
// - Orientation registers update on the same sample strobe as the inertial outputs.

package obt_pkg;

  //========================================================================
  // Register map
  //========================================================================
  localparam int          OBT_ADDR_W          = 7;
  localparam int          OBT_WORD_W          = 16;
  localparam logic [6:0]  OBT_OFS_TEMP        = 7'h0e;
  localparam logic [6:0]  OBT_OFS_PRESS_FINE  = 7'h2e;
  localparam logic [6:0]  OBT_OFS_PRESS_COARSE = 7'h30;
  localparam logic [6:0]  OBT_OFS_PITCH_C31   = 7'h6c;
  localparam logic [6:0]  OBT_OFS_YAW_C32     = 7'h6e;
  localparam logic [6:0]  OBT_OFS_C33         = 7'h70;

  //========================================================================
  // Field layout and codes
  //========================================================================
  localparam int          OBT_FMT_BIT         = 4;
  localparam logic        OBT_FMT_EULER       = 1'b0;
  localparam logic        OBT_FMT_MATRIX      = 1'b1;
  localparam logic [15:0] OBT_PITCH_MAX       = 16'h3fff;
  localparam logic [15:0] OBT_PITCH_MIN       = 16'hc000;
  localparam logic [15:0] OBT_RESET_WORD      = 16'h0000;
  localparam logic [15:0] OBT_UNMAPPED_WORD   = 16'h0000;

  typedef enum {
    OBT_SEL_NONE,
    OBT_SEL_TEMP,
    OBT_SEL_PRESS_FINE,
    OBT_SEL_PRESS_COARSE,
    OBT_SEL_PITCH_C31,
    OBT_SEL_YAW_C32,
    OBT_SEL_C33
  } obt_sel_t;

endpackage

// ---- design/obt_word_reg.sv ----
`timescale 1ns/10ps
`default_nettype none

module obt_word_reg
  import obt_pkg::*;
#(
  parameter int WIDTH = OBT_WORD_W
)
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  //========================================================================
  // Sample-and-hold word
  //========================================================================
  logic [WIDTH-1:0] next_q;

  always_comb
  begin
    next_q = q;
    if (load)
    begin
      next_q = d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      q <= WIDTH'(OBT_RESET_WORD);
    end
    else
    begin
      q <= next_q;
    end
  end

endmodule

`default_nettype wire

// ---- test/obt_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module obt_host_model
(
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid,
  input  wire logic        wrej,
  output var  logic        rd,
  output var  logic        wr,
  output var  logic [6:0]  addr
);
  //====================
  // Register requests
  //====================
  initial
  begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 7'h7f;
  end

  // Every word is taken whole, the coarse pressure alone as well
  task automatic read(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rvalid ? rdata : 16'hxxxx;
  endtask

  // Released address is inverted so a stale value never looks valid
  task automatic write(input logic [6:0] a, output logic r);
    @(posedge clk);
    wr   <= 1'b1;
    addr <= a;
    @(posedge clk);
    wr   <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    r = wrej;
  endtask
endmodule

`default_nettype wire

// ---- test/obt_output_regs_chk.sv ----
`timescale 1ns/10ps
`default_nettype none

module obt_output_regs_chk
  import obt_pkg::*;
#(
  parameter int ADDR_W = OBT_ADDR_W,
  parameter int WORD_W = OBT_WORD_W
)
(
  input wire logic                SYS_CLK,
  input wire logic                RESETN,
  input wire logic [15:0]         ORIENTATION_FILTER_CONFIG,
  input wire logic                SENSOR_STROBE,
  input wire logic [WORD_W-1:0]   PITCH_ANGLE,
  input wire logic [WORD_W-1:0]   YAW_ANGLE,
  input wire logic [WORD_W-1:0]   MATRIX_C31,
  input wire logic [WORD_W-1:0]   MATRIX_C33,
  input wire logic                PRESSURE_STROBE,
  input wire logic [2*WORD_W-1:0] PRESSURE,
  input wire logic                REG_RD,
  input wire logic                REG_WR,
  input wire logic [ADDR_W-1:0]   REG_ADDR,
  input wire logic [WORD_W-1:0]   REG_RDATA,
  input wire logic                REG_RVALID,
  input wire logic                REG_WR_REJECT
);
  //====================
  // Stored word checks
  //====================
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  wire logic eul = SENSOR_STROBE && !ORIENTATION_FILTER_CONFIG[OBT_FMT_BIT];
  wire logic mtx = SENSOR_STROBE && ORIENTATION_FILTER_CONFIG[OBT_FMT_BIT];

  // A strobe in the read cycle would show the old word, so it is excluded
  sequence s_read(a);
    REG_RD && REG_ADDR == a && !SENSOR_STROBE && !PRESSURE_STROBE;
  endsequence

  property p_store(ld, a, e);
    ld ##1 s_read(a) |=> REG_RDATA == e;
  endproperty

  AST_PITCH_HI: assert property (p_store(eul && $signed(PITCH_ANGLE) >
    $signed(OBT_PITCH_MAX), OBT_OFS_PITCH_C31, OBT_PITCH_MAX))
    else $error("pitch above range not clamped");
  AST_PITCH_LO: assert property (p_store(eul && $signed(PITCH_ANGLE) <
    $signed(OBT_PITCH_MIN), OBT_OFS_PITCH_C31, OBT_PITCH_MIN))
    else $error("pitch below range not clamped");
  AST_YAW: assert property (p_store(eul, OBT_OFS_YAW_C32,
    $past(YAW_ANGLE, 2))) else $error("yaw word wrong");
  AST_C31: assert property (p_store(mtx, OBT_OFS_PITCH_C31,
    $past(MATRIX_C31, 2))) else $error("matrix element 31 wrong");
  AST_C33: assert property (p_store(SENSOR_STROBE, OBT_OFS_C33,
    $past(MATRIX_C33, 2))) else $error("matrix element 33 wrong");
  AST_COARSE: assert property (p_store(PRESSURE_STROBE,
    OBT_OFS_PRESS_COARSE, $past(PRESSURE[31:16], 2)))
    else $error("coarse pressure wrong");
  AST_WR_REJECT: assert property (REG_WR |=> REG_WR_REJECT)
    else $error("write not reported");
  AST_IDLE: assert property (!REG_RD |=> !REG_RVALID && $stable(REG_RDATA))
    else $error("read data moved without a read");
endmodule

bind obt_output_regs obt_output_regs_chk #(.ADDR_W(ADDR_W), .WORD_W(WORD_W))
u_chk
(
  .SYS_CLK(SYS_CLK), .RESETN(RESETN),
  .ORIENTATION_FILTER_CONFIG(ORIENTATION_FILTER_CONFIG),
  .SENSOR_STROBE(SENSOR_STROBE), .PITCH_ANGLE(PITCH_ANGLE),
  .YAW_ANGLE(YAW_ANGLE), .MATRIX_C31(MATRIX_C31), .MATRIX_C33(MATRIX_C33),
  .PRESSURE_STROBE(PRESSURE_STROBE), .PRESSURE(PRESSURE), .REG_RD(REG_RD),
  .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .REG_WR_REJECT(REG_WR_REJECT)
);

`default_nettype wire

// ---- test/obt_output_regs_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module obt_output_regs_tb import obt_pkg::*;;
  //====================
  // Bench
  //====================
  logic        sys_clk, resetn, s_stb, p_stb, rd, wr, rvalid, wrej;
  logic [15:0] cfg, pitch, yaw, c31, c32, c33, temp, rdata;
  logic [31:0] press;
  logic [6:0]  addr;
  int          fails, checks_done;

  obt_output_regs dut
  (
    .SYS_CLK(sys_clk), .RESETN(resetn), .ORIENTATION_FILTER_CONFIG(cfg),
    .SENSOR_STROBE(s_stb), .PITCH_ANGLE(pitch), .YAW_ANGLE(yaw),
    .MATRIX_C31(c31), .MATRIX_C32(c32), .MATRIX_C33(c33),
    .TEMPERATURE(temp), .PRESSURE_STROBE(p_stb), .PRESSURE(press),
    .REG_RD(rd), .REG_WR(wr), .REG_ADDR(addr), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .REG_WR_REJECT(wrej)
  );
  obt_host_model u_host
  (
    .clk(sys_clk), .rdata(rdata), .rvalid(rvalid), .wrej(wrej),
    .rd(rd), .wr(wr), .addr(addr)
  );

  task automatic chk(input string n, input logic [15:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rchk(input string n, input logic [6:0] a, logic [15:0] e);
    logic [15:0] d;
    u_host.read(a, d);
    chk(n, d, e);
  endtask

  // Inputs are inverted after the strobe, so only the stored sample can match
  task automatic load(input logic f, input logic [15:0] a, b, c, t);
    @(posedge sys_clk);
    s_stb <= 1'b1;
    cfg   <= f ? 16'hffff : 16'hffef;
    {pitch, c31} <= f ? {~a, a} : {a, ~a};
    {yaw, c32}   <= f ? {~b, b} : {b, ~b};
    {c33, temp}  <= {c, t};
    @(posedge sys_clk);
    s_stb <= 1'b0;
    {cfg, pitch, yaw, c31, c32, c33, temp} <= ~{cfg, pitch, yaw, c31, c32, c33, temp};
  endtask

  task automatic pload(input logic [31:0] v);
    @(posedge sys_clk);
    p_stb <= 1'b1;
    press <= v;
    @(posedge sys_clk);
    p_stb <= 1'b0;
    press <= ~v;
  endtask

  task automatic t_euler();
    logic [15:0] pin [5] = '{16'h5000,16'ha000,16'h3fff,16'hc000,16'h8001};
    logic [15:0] pex [5] = '{16'h3fff,16'hc000,16'h3fff,16'hc000,16'hc000};
    for (int i = 0; i < 5; i++)
    begin
      load(OBT_FMT_EULER, pin[i], pin[i], 16'h8000, 16'hd310);
      rchk("pitch", OBT_OFS_PITCH_C31, pex[i]);
      rchk("yaw", OBT_OFS_YAW_C32, pin[i]);
    end
    rchk("c33", OBT_OFS_C33, 16'h8000);
    rchk("temp", OBT_OFS_TEMP, 16'hd310);
  endtask

  task automatic t_matrix();
    load(OBT_FMT_MATRIX, 16'h8000, 16'h7fff, 16'h0001, 16'h297b);
    rchk("c31", OBT_OFS_PITCH_C31, 16'h8000);
    rchk("c32", OBT_OFS_YAW_C32, 16'h7fff);
    rchk("c33", OBT_OFS_C33, 16'h0001);
    rchk("temp", OBT_OFS_TEMP, 16'h297b);
  endtask

  // Fine word stays with the sample whose coarse word was read first
  task automatic t_press();
    pload(32'h8000_0001);
    rchk("coarse", OBT_OFS_PRESS_COARSE, 16'h8000);
    pload(32'h7fff_ffff);
    rchk("fine", OBT_OFS_PRESS_FINE, 16'h0001);
    rchk("coarse", OBT_OFS_PRESS_COARSE, 16'h7fff);
    rchk("fine", OBT_OFS_PRESS_FINE, 16'hffff);
    pload(32'h0000_8000);
    rchk("fine", OBT_OFS_PRESS_FINE, 16'h8000);
  endtask

  task automatic t_write();
    logic r;
    u_host.write(OBT_OFS_PITCH_C31, r);
    chk("reject", {15'h0000, r}, 16'h0001);
    rchk("pitch kept", OBT_OFS_PITCH_C31, 16'h8000);
    rchk("unmapped", 7'h01, OBT_UNMAPPED_WORD);
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  begin
    fails = 0;
    checks_done = 0;
    {resetn, s_stb, p_stb} = 3'h0;
    {cfg, pitch, yaw, c31, c32, c33, temp} = {7{16'h0000}};
    press = 32'h0000_0000;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rchk("reset", OBT_OFS_C33, OBT_RESET_WORD);
    t_euler();
    t_matrix();
    t_press();
    t_write();
    complete_run();
  end

  // Whole sequence needs about 100 cycles
  initial
  begin
    repeat (600) @(posedge sys_clk);
    fails++;
    complete_run();
  end
endmodule

`default_nettype wire
